// File: core/ame_defs.vh
// constants for the address mode evaluator
// Operation
// - word register plus signed offset forms low address
// - bank byte chosen by word register number
// - long register plus signed offset, low 24 bits
// - pc offset address is pc plus 4 plus offset
// - pc offset never uses next instruction address
// - base index adds register 0/1 to register 7
// - relative branch wraps within program bank
// - accumulator data access uses data bank
// - accumulator branch uses program bank, context jump data bank
// - memory indirect branch reads target word from memory
// - time is base plus correction plus fetch cycles
// - fetch words on 16-bit, bytes on 8-bit bus
// - intermittent mode halts clock per access by select bits
// - intermittent adds access count times halt cycles
// - base cycles and register accesses per address mode
// - operand correction by bus, alignment and size
// - external bus wait cycles stretch execution
// - fetch correction per bus and boundary
// - fetch corrections are worst case bounds only
// - post increment adds 1, 2 or 4
// - extension byte count per address code
`ifndef AME_DEFS_VH
`define AME_DEFS_VH
// apb byte offsets
`define AME_A_CTRL 8'h00
`define AME_A_CMD 8'h04
`define AME_A_BANK 8'h08
`define AME_A_PC 8'h0c
`define AME_A_GPR01 8'h10
`define AME_A_GPR23 8'h14
`define AME_A_GPR45 8'h18
`define AME_A_GPR67 8'h1c
`define AME_A_DISP 8'h20
`define AME_A_ACC 8'h24
`define AME_A_BASE 8'h28
`define AME_A_EA 8'h30
`define AME_A_CYC 8'h34
`define AME_A_STAT 8'h38
// control fields
`define AME_F_CODE 4:0
`define AME_F_CLASS 7:5
`define AME_F_SIZE 9:8
`define AME_F_BUS 11:10
`define AME_F_FBUS 13:12
`define AME_F_FBND 14
`define AME_F_INTM 15
`define AME_F_HSLO 16
`define AME_F_HSHI 17
`define AME_F_USTK 18
`define AME_F_CTX 19
// bank and program counter fields
`define AME_F_DBANK 7:0
`define AME_F_SBANK 15:8
`define AME_F_UBANK 23:16
`define AME_F_XBANK 31:24
`define AME_F_PBANK 23:16
`define AME_F_PCLO 15:0
// address mode classes
`define AME_CL_EAM 3'h0
`define AME_CL_LONG 3'h1
`define AME_CL_REL 3'h2
`define AME_CL_ACC 3'h3
`define AME_CL_ACCBR 3'h4
`define AME_CL_IND 3'h5
// operand sizes
`define AME_SZ_BYTE 2'h0
`define AME_SZ_WORD 2'h1
`define AME_SZ_LONG 2'h2
// operand bus kinds
`define AME_BUS_REG 2'h0
`define AME_BUS_INT 2'h1
`define AME_BUS_E16 2'h2
`define AME_BUS_E8 2'h3
// fetch bus kinds
`define AME_FB_INT 2'h0
`define AME_FB_E16 2'h1
`define AME_FB_E8 2'h2
// mode cycle / register access figures
`define AME_CYC_RI 5'h02
`define AME_ACC_RI 5'h01
`define AME_CYC_PI 5'h04
`define AME_ACC_PI 5'h02
`define AME_CYC_DSP 5'h02
`define AME_ACC_DSP 5'h01
`define AME_CYC_IDX 5'h04
`define AME_ACC_IDX 5'h02
`define AME_CYC_PCD 5'h02
`define AME_ACC_PCD 5'h00
`define AME_CYC_DIR 5'h01
`define AME_ACC_DIR 5'h00
// operand correction figures
`define AME_OC_ODDW 5'h02
`define AME_OC_ODDL 5'h04
`define AME_OC_E1 5'h01
`define AME_OC_E2 5'h02
`define AME_OC_E4 5'h04
`define AME_OC_E8 5'h08
`define AME_OA_1 5'h01
`define AME_OA_2 5'h02
`define AME_OA_4 5'h04
// fetch correction figures
`define AME_FC_INT 5'h02
`define AME_FC_EXT 5'h03
// pc offset bias
`define AME_PC_BIAS 16'h0004
// halt cycles per select code
`define AME_HALT0 8'h00
`define AME_HALT1 8'h08
`define AME_HALT2 8'h10
`define AME_HALT3 8'h20
// fsm states
`define AME_S_IDLE 2'h0
`define AME_S_MEM 2'h1
`define AME_S_DONE 2'h2
`endif

// File: core/ame_core.v
// address mode evaluator with cycle accounting, apb slave
`timescale 1ns/1ps
`default_nettype none
`include "ame_defs.vh"
module ame_core (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // operand memory read port
   output reg mem_req,
   output reg [23:0] mem_addr,
   input wire [15:0] mem_rdata,
   input wire mem_ack
);
   localparam S_IDLE = `AME_S_IDLE;
   localparam S_MEM = `AME_S_MEM;
   localparam S_DONE = `AME_S_DONE;

   reg [19:0] ctrl_r;
   reg [31:0] bank_r;
   reg [23:0] pc_r;
   reg [15:0] disp_r;
   reg [15:0] acc_r;
   reg [15:0] base_r;
   reg [15:0] gpr_r [0:7];
   reg [1:0] state_r;
   reg [23:0] ea_r;
   reg [15:0] cyc_r;
   reg [4:0] acc_cnt_r;
   reg [15:0] wait_r;
   reg done_r;
   integer i;

   wire wr_en = psel & penable & pwrite;
   wire rd_setup = psel & ~penable & ~pwrite;
   wire start = wr_en & (paddr == `AME_A_CMD) & pwdata[0] & (state_r != S_MEM);

   wire [4:0] code = ctrl_r[`AME_F_CODE];
   wire [2:0] cls = ctrl_r[`AME_F_CLASS];
   wire [1:0] osz = ctrl_r[`AME_F_SIZE];
   wire [1:0] obus = ctrl_r[`AME_F_BUS];
   wire [1:0] fbus = ctrl_r[`AME_F_FBUS];
   wire [7:0] data_bank_sel = bank_r[`AME_F_DBANK];
   wire [7:0] system_stack_bank = bank_r[`AME_F_SBANK];
   wire [7:0] user_stack_bank = bank_r[`AME_F_UBANK];
   wire [7:0] extra_data_bank = bank_r[`AME_F_XBANK];
   wire [7:0] program_bank = pc_r[`AME_F_PBANK];
   wire [15:0] pc_lo = pc_r[`AME_F_PCLO];
   wire [15:0] acc_low_half = acc_r;
   wire context_jump_op = ctrl_r[`AME_F_CTX];

   // only the 8-bit offset codes reach registers 4 to 7; the rest use two bits
   wire [2:0] ridx = (code[4:3] == 2'b10) ? code[2:0] : {1'b0, code[1:0]};
   wire [15:0] rw = gpr_r[ridx];
   wire [15:0] d8 = {{8{disp_r[7]}}, disp_r[7:0]};
   wire [31:0] long_gpr = {gpr_r[{code[1:0], 1'b1}], gpr_r[{code[1:0], 1'b0}]};
   wire [31:0] lsum = long_gpr + {{24{disp_r[7]}}, disp_r[7:0]};

   // 16-bit sums wrap inside the bank: no carry path to bits 23:16
   wire [15:0] sum_d8 = rw + d8;
   wire [15:0] sum_d16 = rw + disp_r;
   wire [15:0] sum_idx = gpr_r[{2'b00, code[0]}] + gpr_r[7];
   wire [15:0] sum_pc = pc_lo + `AME_PC_BIAS + disp_r;
   wire [15:0] sum_rel = pc_lo + d8;
   wire [15:0] inc_val = (osz == `AME_SZ_BYTE) ? 16'h0001 :
                         (osz == `AME_SZ_WORD) ? 16'h0002 : 16'h0004;

   // bank byte by register number
   reg [7:0] rbank;
   always @* begin
      case (ridx[1:0])
         2'h3: rbank = ctrl_r[`AME_F_USTK] ? user_stack_bank : system_stack_bank;
         2'h2: rbank = extra_data_bank;
         default: rbank = data_bank_sel;
      endcase
   end

   // effective address of an eam operand
   reg [23:0] eam_addr;
   reg [4:0] mcyc;
   reg [4:0] macc;
   reg [1:0] ext_bytes;
   always @* begin
      eam_addr = 24'h000000;
      mcyc = 5'h00;
      macc = 5'h00;
      ext_bytes = 2'h0;
      case (code[4:2])
         3'h2: begin
            eam_addr = {rbank, rw};
            mcyc = `AME_CYC_RI;
            macc = `AME_ACC_RI;
         end
         3'h3: begin
            eam_addr = {rbank, rw};
            mcyc = `AME_CYC_PI;
            macc = `AME_ACC_PI;
         end
         3'h4, 3'h5: begin
            eam_addr = {rbank, sum_d8};
            mcyc = `AME_CYC_DSP;
            macc = `AME_ACC_DSP;
            ext_bytes = 2'h1;
         end
         3'h6: begin
            eam_addr = {rbank, sum_d16};
            mcyc = `AME_CYC_DSP;
            macc = `AME_ACC_DSP;
            ext_bytes = 2'h2;
         end
         3'h7: begin
            if (code[1] == 1'b0) begin
               eam_addr = {data_bank_sel, sum_idx};
               mcyc = `AME_CYC_IDX;
               macc = `AME_ACC_IDX;
            end else if (code[0] == 1'b0) begin
               // instruction address plus 4, whatever the instruction length
               eam_addr = {program_bank, sum_pc};
               mcyc = `AME_CYC_PCD;
               macc = `AME_ACC_PCD;
               ext_bytes = 2'h2;
            end else begin
               eam_addr = {data_bank_sel, disp_r};
               mcyc = `AME_CYC_DIR;
               macc = `AME_ACC_DIR;
               ext_bytes = 2'h2;
            end
         end
         default: begin
            eam_addr = 24'h000000;
         end
      endcase
   end

   // address per class and whether an operand access is made
   reg [23:0] addr_c;
   reg use_op;
   reg use_mode;
   always @* begin
      addr_c = 24'h000000;
      use_op = 1'b0;
      use_mode = 1'b0;
      case (cls)
         `AME_CL_EAM: begin
            addr_c = eam_addr;
            use_op = 1'b1;
            use_mode = 1'b1;
         end
         `AME_CL_LONG: begin
            addr_c = lsum[23:0];
            use_op = 1'b1;
         end
         `AME_CL_REL: begin
            addr_c = {program_bank, sum_rel};
         end
         `AME_CL_ACC: begin
            addr_c = {data_bank_sel, acc_low_half};
            use_op = 1'b1;
         end
         `AME_CL_ACCBR: begin
            addr_c = {context_jump_op ? data_bank_sel : program_bank, acc_low_half};
         end
         `AME_CL_IND: begin
            addr_c = eam_addr;
            use_op = 1'b1;
            use_mode = 1'b1;
         end
         default: begin
            addr_c = 24'h000000;
         end
      endcase
   end

   // operand correction cycles and access counts
   reg [4:0] ocyc;
   reg [4:0] oacc;
   wire odd = addr_c[0];
   always @* begin
      ocyc = 5'h00;
      oacc = (osz == `AME_SZ_LONG) ? `AME_OA_2 : `AME_OA_1;
      case (obus)
         `AME_BUS_INT: begin
            if (odd && osz == `AME_SZ_WORD) begin
               ocyc = `AME_OC_ODDW;
               oacc = `AME_OA_2;
            end else if (odd && osz == `AME_SZ_LONG) begin
               ocyc = `AME_OC_ODDL;
               oacc = `AME_OA_4;
            end
         end
         `AME_BUS_E16, `AME_BUS_E8: begin
            if (osz == `AME_SZ_BYTE) begin
               ocyc = `AME_OC_E1;
            end else if (obus == `AME_BUS_E16 && !odd) begin
               ocyc = (osz == `AME_SZ_WORD) ? `AME_OC_E1 : `AME_OC_E2;
            end else if (osz == `AME_SZ_WORD) begin
               ocyc = `AME_OC_E4;
               oacc = `AME_OA_2;
            end else begin
               ocyc = `AME_OC_E8;
               oacc = `AME_OA_4;
            end
         end
         default: begin
            ocyc = 5'h00;
         end
      endcase
   end

   // fetch correction; worst case bound, applied only when flagged at a boundary
   reg [4:0] fcyc;
   always @* begin
      fcyc = 5'h00;
      if (ctrl_r[`AME_F_FBND]) begin
         case (fbus)
            `AME_FB_INT: fcyc = `AME_FC_INT;
            `AME_FB_E16: fcyc = `AME_FC_EXT;
            `AME_FB_E8: fcyc = `AME_FC_EXT;
            default: fcyc = 5'h00;
         endcase
      end
   end

   // intermittent clock halt per access
   reg [7:0] halt_cyc;
   always @* begin
      case ({ctrl_r[`AME_F_HSHI], ctrl_r[`AME_F_HSLO]})
         2'h0: halt_cyc = `AME_HALT0;
         2'h1: halt_cyc = `AME_HALT1;
         2'h2: halt_cyc = `AME_HALT2;
         default: halt_cyc = `AME_HALT3;
      endcase
   end

   wire [4:0] mode_cyc = use_mode ? mcyc : 5'h00;
   wire [4:0] mode_acc = use_mode ? macc : 5'h00;
   wire [4:0] op_cyc = use_op ? ocyc : 5'h00;
   wire [4:0] op_acc = use_op ? oacc : 5'h00;
   wire [4:0] acc_tot = mode_acc + op_acc;
   wire [15:0] halt_tot = ctrl_r[`AME_F_INTM] ? ({11'h000, acc_tot} * {8'h00, halt_cyc}) :
                          16'h0000;
   wire [15:0] cyc_c = base_r + {11'h000, mode_cyc} + {11'h000, op_cyc} +
                       {11'h000, fcyc} + halt_tot;
   wire ext_op = (obus == `AME_BUS_E16) | (obus == `AME_BUS_E8);

   // control, state and result registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= 20'h00000;
         bank_r <= 32'h00000000;
         pc_r <= 24'h000000;
         disp_r <= 16'h0000;
         acc_r <= 16'h0000;
         base_r <= 16'h0000;
         for (i = 0; i < 8; i = i + 1) begin
            gpr_r[i] <= 16'h0000;
         end
         state_r <= S_IDLE;
         ea_r <= 24'h000000;
         cyc_r <= 16'h0000;
         acc_cnt_r <= 5'h00;
         wait_r <= 16'h0000;
         done_r <= 1'b0;
         mem_req <= 1'b0;
         mem_addr <= 24'h000000;
      end else begin
         if (wr_en) begin
            case (paddr)
               `AME_A_CTRL: ctrl_r <= pwdata[19:0];
               `AME_A_BANK: bank_r <= pwdata;
               `AME_A_PC: pc_r <= pwdata[23:0];
               `AME_A_GPR01: begin
                  gpr_r[0] <= pwdata[15:0];
                  gpr_r[1] <= pwdata[31:16];
               end
               `AME_A_GPR23: begin
                  gpr_r[2] <= pwdata[15:0];
                  gpr_r[3] <= pwdata[31:16];
               end
               `AME_A_GPR45: begin
                  gpr_r[4] <= pwdata[15:0];
                  gpr_r[5] <= pwdata[31:16];
               end
               `AME_A_GPR67: begin
                  gpr_r[6] <= pwdata[15:0];
                  gpr_r[7] <= pwdata[31:16];
               end
               `AME_A_DISP: disp_r <= pwdata[15:0];
               `AME_A_ACC: acc_r <= pwdata[15:0];
               `AME_A_BASE: base_r <= pwdata[15:0];
               default: begin
               end
            endcase
         end
         case (state_r)
            S_IDLE, S_DONE: begin
               if (start) begin
                  ea_r <= addr_c;
                  cyc_r <= cyc_c;
                  acc_cnt_r <= acc_tot;
                  wait_r <= 16'h0000;
                  done_r <= 1'b0;
                  // post increment writes back on the start edge, as ea_r captures the address from the old value
                  if (cls == `AME_CL_EAM && code[4:2] == 3'h3) begin
                     gpr_r[ridx] <= rw + inc_val;
                  end
                  if (cls == `AME_CL_IND) begin
                     mem_req <= 1'b1;
                     mem_addr <= addr_c;
                     state_r <= S_MEM;
                  end else begin
                     done_r <= 1'b1;
                     state_r <= S_DONE;
                  end
               end
            end
            S_MEM: begin
               if (mem_ack) begin
                  mem_req <= 1'b0;
                  ea_r <= {program_bank, mem_rdata};
                  done_r <= 1'b1;
                  state_r <= S_DONE;
               end else if (ext_op) begin
                  // each stalled cycle on an external bus counts as a wait
                  wait_r <= wait_r + 16'h0001;
                  cyc_r <= cyc_r + 16'h0001;
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // read data is captured in the setup phase so it comes from a flip-flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (rd_setup) begin
         case (paddr)
            `AME_A_CTRL: prdata <= {12'h000, ctrl_r};
            `AME_A_BANK: prdata <= bank_r;
            `AME_A_PC: prdata <= {8'h00, pc_r};
            `AME_A_GPR01: prdata <= {gpr_r[1], gpr_r[0]};
            `AME_A_GPR23: prdata <= {gpr_r[3], gpr_r[2]};
            `AME_A_GPR45: prdata <= {gpr_r[5], gpr_r[4]};
            `AME_A_GPR67: prdata <= {gpr_r[7], gpr_r[6]};
            `AME_A_DISP: prdata <= {16'h0000, disp_r};
            `AME_A_ACC: prdata <= {16'h0000, acc_r};
            `AME_A_BASE: prdata <= {16'h0000, base_r};
            `AME_A_EA: prdata <= {8'h00, ea_r};
            `AME_A_CYC: prdata <= {16'h0000, cyc_r};
            `AME_A_STAT: prdata <= {wait_r, 7'h00, acc_cnt_r, ext_bytes, done_r,
                                    state_r == S_MEM};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   wire mapped = (paddr[1:0] == 2'b00) && ((paddr <= `AME_A_BASE) ||
                 (paddr >= `AME_A_EA && paddr <= `AME_A_STAT));
   assign pready = 1'b1;
   // zero wait states; unmapped or misaligned addresses answer with an error
   assign pslverr = psel & penable & ~mapped;
endmodule // ame_core
`default_nettype wire

// File: verification/ame_mem_model.sv
// operand memory model answering the evaluator's read port
`timescale 1ns/1ps
`default_nettype none
module ame_mem_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // read request
   input wire logic mem_req,
   input wire logic [23:0] mem_addr,
   // answer
   output logic [15:0] mem_rdata,
   output logic mem_ack,
   // answer delay in cycles
   input wire logic [3:0] lat
);
   logic [3:0] cnt_r;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 4'h0;
         mem_ack <= 1'b0;
         mem_rdata <= 16'h0000;
      end else if (mem_req && !mem_ack && cnt_r == lat) begin
         mem_ack <= 1'b1;
         mem_rdata <= mem_addr[15:0] ^ 16'ha5c3;
      end else begin
         mem_ack <= 1'b0;
         // released bus must not keep showing the last word
         mem_rdata <= ~mem_rdata;
         cnt_r <= (mem_req && !mem_ack) ? cnt_r + 4'h1 : 4'h0;
      end
   end
endmodule // ame_mem_model
`default_nettype wire

// File: verification/ame_core_props.sv
// assertions on the evaluator's bus and memory ports
`timescale 1ns/1ps
`default_nettype none
module ame_core_props (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // memory port
   input wire logic mem_req,
   input wire logic [23:0] mem_addr,
   input wire logic mem_ack
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence acc_ph;
      psel && penable;
   endsequence
   sequence mem_wait;
      mem_req && !mem_ack;
   endsequence
   pready_up_a: assert property (pready) else $error("pready low");
   rd_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("prdata moved outside read setup");
   err_phase_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
   err_hole_a: assert property (acc_ph ##0 paddr == 8'h2c |-> pslverr)
      else $error("hole not refused");
   hole_zero_a: assert property (acc_ph ##0 (!pwrite && paddr == 8'h2c) |-> prdata == 32'h0)
      else $error("hole read not zero");
   req_cause_a: assert property ($rose(mem_req) |->
      $past(psel && penable && pwrite && paddr == 8'h04 && pwdata[0])) else $error("req no start");
   req_hold_a: assert property (mem_wait |=> mem_req) else $error("req dropped");
   addr_hold_a: assert property (mem_wait |=> $stable(mem_addr)) else $error("addr moved");
   req_drop_a: assert property (mem_req && mem_ack |=> !mem_req) else $error("req held");
   req_fall_a: assert property ($fell(mem_req) |-> $past(mem_ack)) else $error("req fell early");
endmodule // ame_core_props
bind ame_core ame_core_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack));
`default_nettype wire

// File: verification/cpu_addr_mode_eval_bench.sv
// self-checking bench for the address mode evaluator
`timescale 1ns/1ps
`default_nettype none
`include "ame_defs.vh"
module cpu_addr_mode_eval_bench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, mem_req, mem_ack, er;
   logic [23:0] mem_addr, req_addr;
   logic [15:0] mem_rdata;
   logic [3:0] lat = 4'h0;
   logic [31:0] rd;
   int err_total = 0;
   int cmp_count = 0;
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) if (mem_req === 1'b1) req_addr <= mem_addr;
   ame_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack));
   ame_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .lat(lat));
   task automatic finish_test();
      $display("mismatches %0d of %0d compares", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         err_total++;
         finish_test();
      end
   endtask
   // poll the done flag; an indirect branch may sit on a slow memory
   task automatic run(input logic [31:0] ctrl);
      int n;
      n = 0;
      apb(1'b1, `AME_A_CTRL, ctrl);
      apb(1'b1, `AME_A_CMD, 32'h1);
      do begin
         apb(1'b0, `AME_A_STAT, 32'h0);
         n++;
      end while (rd[1] !== 1'b1 && n < 40);
      if (n >= 40) begin
         err_total++;
         finish_test();
      end
   endtask
   task automatic ea(input logic [31:0] ctrl, input logic [31:0] exp);
      run(ctrl);
      apb(1'b0, `AME_A_EA, 32'h0);
      chk(rd, exp);
   endtask
   task automatic setup();
      apb(1'b1, `AME_A_BANK, 32'h44332211);
      apb(1'b1, `AME_A_PC, 32'h00550008);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `AME_A_GPR01 + 8'(4 * i), {16'(9 + 2 * i), 16'(8 + 2 * i)});
      end
      apb(1'b1, `AME_A_DISP, 32'h0000fff0);
      apb(1'b1, `AME_A_ACC, 32'h00001234);
      apb(1'b1, `AME_A_BASE, 32'h00000005);
   endtask
   // negative offset wraps each offset sum inside its bank
   task automatic t_offsets();
      logic [7:0] bk;
      for (int c = 16; c < 28; c++) begin
         bk = (c % 4 == 3) ? 8'h22 : (c % 4 == 2) ? 8'h44 : 8'h11;
         ea(32'(c), {8'h0, bk, 16'hfff8 + 16'(c % 8)});
         apb(1'b0, `AME_A_STAT, 32'h0);
         chk({30'h0, rd[3:2]}, (c < 24) ? 32'h1 : 32'h2);
      end
      ea(32'h00040013, 32'h0033fffb);
      ea(32'h0000001c, 32'h00110017);
      ea(32'h0000001d, 32'h00110018);
      ea(32'h0000001e, 32'h0055fffc);
   endtask
   task automatic t_classes();
      ea(32'h00000020, 32'h0008fff8);
      ea(32'h00000040, 32'h0055fff8);
      ea(32'h00000060, 32'h00111234);
      ea(32'h00000080, 32'h00551234);
      ea(32'h00080080, 32'h00111234);
   endtask
   task automatic t_cycles();
      int h [4] = '{0, 8, 16, 32};
      run(32'h00000908);
      apb(1'b0, `AME_A_CYC, 32'h0);
      chk(rd, 32'h8);
      apb(1'b0, `AME_A_STAT, 32'h0);
      chk({27'h0, rd[8:4]}, 32'h2);
      run(32'h0000051e);
      apb(1'b0, `AME_A_CYC, 32'h0);
      chk(rd, 32'h7);
      for (int s = 0; s < 4; s++) begin
         run(32'h0000e61c | 32'(s << 16));
         apb(1'b0, `AME_A_CYC, 32'h0);
         chk(rd, 32'(16 + 6 * h[s]));
      end
   endtask
   task automatic t_indirect();
      logic [31:0] c0;
      lat <= 4'h0;
      ea(32'h000008bc, 32'h0055a5d4);
      chk({8'h0, req_addr}, 32'h00110017);
      apb(1'b0, `AME_A_CYC, 32'h0);
      c0 = rd;
      lat <= 4'h3;
      run(32'h000008bc);
      apb(1'b0, `AME_A_CYC, 32'h0);
      chk(rd - c0, 32'h3);
      apb(1'b0, `AME_A_STAT, 32'h0);
      chk({16'h0, rd[31:16]}, 32'h4);
   endtask
   // operand bus, alignment, size and fetch bus corrections not met elsewhere
   task automatic t_buses();
      logic [31:0] c [7] = '{32'h5c1f, 32'h091c, 32'h0e1c, 32'h0a1f, 32'h421f, 32'h051d,
                             32'h0d1f};
      int ec [7] = '{10, 13, 17, 8, 8, 9, 10};
      int na [7] = '{1, 4, 6, 2, 2, 3, 2};
      for (int k = 0; k < 7; k++) begin
         run(c[k]);
         apb(1'b0, `AME_A_CYC, 32'h0);
         chk(rd, 32'(ec[k]));
         apb(1'b0, `AME_A_STAT, 32'h0);
         chk({27'h0, rd[8:4]}, 32'(na[k]));
      end
      ea(32'h0000001f, 32'h0011fff0);
   endtask
   task automatic t_postinc();
      logic [15:0] g;
      g = 16'h0008;
      for (int s = 0; s < 3; s++) begin
         ea(32'h0000000c | 32'(s << 8), {16'h0011, g});
         g = g + 16'(1 << s);
         apb(1'b0, `AME_A_GPR01, 32'h0);
         chk(rd, {16'h0009, g});
      end
   endtask
   task automatic t_unmapped();
      apb(1'b0, 8'h2c, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b0, `AME_A_ACC, 32'h0);
      chk({31'h0, er}, 32'h0);
      chk(rd, 32'h00001234);
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      setup();
      t_offsets();
      t_classes();
      t_cycles();
      t_indirect();
      t_buses();
      t_postinc();
      t_unmapped();
      finish_test();
   end
endmodule // cpu_addr_mode_eval_bench
`default_nettype wire
